// ### dac_serial_regs.vh
/*
 * Constants for the serial load chain of a 16-bit converter: word layout,
 * bit counting, synchroniser depth and reset values.
 * Assumes it is included by bare name from the design files of this block.
 */
`ifndef DAC_SERIAL_REGS_VH
`define DAC_SERIAL_REGS_VH

`define WORD_BITS 16
`define WORD_MSB 15
`define WORD_RESET 16'h0000
`define COUNT_BITS 5
`define COUNT_RESET 5'h00
`define COUNT_FULL 5'h10
`define PIN_COUNT 5
`define PIN_SCLK 0
`define PIN_DATA 1
`define PIN_FRAME 2
`define PIN_STROBE 3
`define PIN_CHAIN 4
`define PIN_RESET_IDLE 5'h0C
`define SYNC_STAGES 2
`define FILL_BITS 2
`define FILL_EMPTY 2'h0
`define FILL_ONE 2'h1
`define FILL_TWO 2'h2
`define MIN_STROBE_NS 100
`define MAX_SCLK_MHZ 5
`define CLOCK_MHZ 125

`endif

// ### word_pair_buffer.v
/*
 * Two-entry buffer with valid and ready on both sides, holding converter
 * words between the update logic and the latch consumer.
 * Assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`include "dac_serial_regs.vh"

module word_pair_buffer (
    input wire clock,
    input wire rstn,
    input wire in_valid,
    output wire in_ready,
    input wire [`WORD_MSB:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [`WORD_MSB:0] out_data
);
    reg [`WORD_MSB:0] slot0;
    reg [`WORD_MSB:0] slot1;
    reg [`FILL_BITS-1:0] fill;
    wire push;
    wire pop;

    assign in_ready = (fill != `FILL_TWO);
    assign out_valid = (fill != `FILL_EMPTY);
    assign out_data = slot0;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clock) begin
        if (!rstn) begin
            slot0 <= `WORD_RESET;
            slot1 <= `WORD_RESET;
            fill <= `FILL_EMPTY;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (fill == `FILL_EMPTY) begin
                        slot0 <= in_data;
                    end else begin
                        slot1 <= in_data;
                    end
                    fill <= fill + `FILL_ONE;
                end
                2'b01: begin
                    slot0 <= slot1;
                    fill <= fill - `FILL_ONE;
                end
                2'b11: begin
                    // Fill stays put: the oldest word leaves as the new one enters.
                    if (fill == `FILL_ONE) begin
                        slot0 <= in_data;
                    end else begin
                        slot0 <= slot1;
                        slot1 <= in_data;
                    end
                end
                default: begin
                    fill <= fill;
                end
            endcase
        end
    end
endmodule

// ### dac_serial_load_chain.v
/*
 * Serial input and update logic of a 16-bit converter: shift register,
 * automatic or strobed transfer to the latch, and daisy-chain output.
 * Assumes all serial pins come from another clock domain and that the
 * serial clock is far slower than the system clock, so every edge is seen.
 * A pin level must stand for more than one system clock period to be sure of being seen,
 * which bounds the serial clock rate that the block can follow.
 */
`timescale 1ns/10ps
`include "dac_serial_regs.vh"

module dac_serial_load_chain (
    input wire clock,
    input wire rstn,
    input wire serial_clk,
    input wire serial_data,
    input wire frame_sync_n,
    input wire load_strobe_n,
    input wire chain_enable,
    input wire latch_ready,
    output wire latch_valid,
    output wire [`WORD_MSB:0] latch_word,
    output reg [`WORD_MSB:0] dac_latch,
    output reg dac_updated,
    output reg update_pending,
    output reg word_complete,
    output reg serial_chain_out
);
    localparam IDLE = 2'b00;
    localparam SHIFT = 2'b01;
    localparam LOADED = 2'b10;
    localparam [`PIN_COUNT-1:0] PINS_IDLE = `PIN_RESET_IDLE;

    wire [`PIN_COUNT-1:0] pins_raw;
    wire [`PIN_COUNT-1:0] pins;
    reg [`PIN_COUNT-1:0] pins_last;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [`WORD_MSB:0] shift_word;
    reg [`COUNT_BITS-1:0] bit_count;
    reg [`WORD_MSB:0] held_word;
    wire sclk_fall;
    wire frame_active;
    wire strobe_fall;
    wire auto_mode;
    wire chain_on;
    wire sixteenth_edge;
    wire update_request;
    wire buf_in_ready;
    wire buf_push;
    wire pop;

    assign pins_raw = {chain_enable, load_strobe_n, frame_sync_n, serial_data, serial_clk};

    // Each pin gets its own two-stage synchroniser; the first stage feeds only the second.
    // Both stages reset to the pin's idle level, so no false edge follows reset.
    genvar i;
    generate
        for (i = 0; i < `PIN_COUNT; i = i + 1) begin : pin_sync
            reg meta;
            reg stable;
            always @(posedge clock) begin
                if (!rstn) begin
                    meta <= PINS_IDLE[i];
                    stable <= PINS_IDLE[i];
                end else begin
                    meta <= pins_raw[i];
                    stable <= meta;
                end
            end
            assign pins[i] = stable;
        end
    endgenerate

    always @(posedge clock) begin
        if (!rstn) begin
            pins_last <= `PIN_RESET_IDLE;
        end else begin
            pins_last <= pins;
        end
    end

    assign frame_active = ~pins[`PIN_FRAME];
    assign sclk_fall = pins_last[`PIN_SCLK] & ~pins[`PIN_SCLK];
    assign strobe_fall = pins_last[`PIN_STROBE] & ~pins[`PIN_STROBE];
    assign auto_mode = ~pins[`PIN_STROBE];
    assign chain_on = pins[`PIN_CHAIN];
    assign sixteenth_edge = frame_active & sclk_fall & (bit_count == `COUNT_FULL - 5'h01);

    // A strobe edge and the sixteenth edge in the same cycle are one update, not two.
    // A strobe that falls inside a frame moves a partly shifted word, so the
    // host must strobe only after frame sync has gone high again.
    assign update_request = strobe_fall | (sixteenth_edge & auto_mode);

    always @* begin
        next_state = state;
        case (state)
            IDLE: begin
                if (frame_active) begin
                    next_state = SHIFT;
                end
            end
            SHIFT: begin
                if (!frame_active) begin
                    next_state = IDLE;
                end else if (sixteenth_edge) begin
                    next_state = LOADED;
                end
            end
            LOADED: begin
                if (!frame_active) begin
                    next_state = IDLE;
                end
            end
            default: begin
                next_state = IDLE;
            end
        endcase
    end

    // The frame state only tells a new frame from one already under way.
    always @(posedge clock) begin
        if (!rstn) begin
            state <= IDLE;
        end else begin
            state <= next_state;
        end
    end

    // The counter stops at sixteen, so later edges in a chain keep shifting
    // but can never raise a second automatic update in the same frame.
    always @(posedge clock) begin
        if (!rstn) begin
            bit_count <= `COUNT_RESET;
        end else if (!frame_active) begin
            bit_count <= `COUNT_RESET;
        end else if (sclk_fall && bit_count != `COUNT_FULL) begin
            bit_count <= bit_count + 5'h01;
        end
    end

    // Bits are taken most significant first; the register keeps its contents
    // after the frame ends, so a later strobe still finds the whole word.
    always @(posedge clock) begin
        if (!rstn) begin
            shift_word <= `WORD_RESET;
        end else if (frame_active && sclk_fall) begin
            shift_word <= {shift_word[`WORD_MSB-1:0], pins[`PIN_DATA]};
        end
    end

    // The flag stands from the sixteenth edge until the next frame opens.
    always @(posedge clock) begin
        if (!rstn) begin
            word_complete <= 1'b0;
        end else if (sixteenth_edge) begin
            word_complete <= 1'b1;
        end else if (frame_active && state == IDLE) begin
            word_complete <= 1'b0;
        end
    end

    // The bit leaving the top of the register goes on to the next device.
    // With chaining off the pin stays low rather than echoing the register.
    always @(posedge clock) begin
        if (!rstn) begin
            serial_chain_out <= 1'b0;
        end else if (chain_on) begin
            serial_chain_out <= shift_word[`WORD_MSB];
        end else begin
            serial_chain_out <= 1'b0;
        end
    end

    // An update the buffer cannot take yet is held, not dropped; a second
    // update while one is held overwrites the held word with the newer one.
    always @(posedge clock) begin
        if (!rstn) begin
            update_pending <= 1'b0;
            held_word <= `WORD_RESET;
        end else if (update_request) begin
            held_word <= sixteenth_edge ? {shift_word[`WORD_MSB-1:0], pins[`PIN_DATA]}
                                        : shift_word;
            update_pending <= 1'b1;
        end else if (buf_push) begin
            update_pending <= 1'b0;
        end
    end

    assign buf_push = update_pending & buf_in_ready;
    assign pop = latch_valid & latch_ready;

    // Two buffered words let the consumer stall briefly before updates wait.
    word_pair_buffer u_word_buffer (
        .clock(clock),
        .rstn(rstn),
        .in_valid(update_pending),
        .in_ready(buf_in_ready),
        .in_data(held_word),
        .out_valid(latch_valid),
        .out_ready(latch_ready),
        .out_data(latch_word)
    );

    // The update flag marks the cycle in which the new word stands in the latch.
    always @(posedge clock) begin
        if (!rstn) begin
            dac_updated <= 1'b0;
        end else begin
            dac_updated <= pop;
        end
    end

    // Every device on the shared strobe moves its word here in the same way,
    // so the chain updates together a fixed few cycles after the strobe edge while latch_ready stays high.
    always @(posedge clock) begin
        if (!rstn) begin
            dac_latch <= `WORD_RESET;
        end else if (pop) begin
            dac_latch <= latch_word;
        end
    end
endmodule

// ### dac_load_properties.sv
/* Assertions on the serial load chain ports.
   Assumes one clock domain with a synchronous active-low reset. */
`timescale 1ns/10ps
module dac_load_checker (
    input wire clock,
    input wire rstn,
    input wire serial_clk,
    input wire serial_data,
    input wire frame_sync_n,
    input wire load_strobe_n,
    input wire chain_enable,
    input wire latch_ready,
    input wire latch_valid,
    input wire [15:0] latch_word,
    input wire [15:0] dac_latch,
    input wire dac_updated,
    input wire update_pending,
    input wire word_complete,
    input wire serial_chain_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    chk_update_pulse: assert property (!(latch_valid && latch_ready) |=> !dac_updated)
        else $error("update flag without latch load");
    chk_pop_load: assert property (latch_valid && latch_ready |=> dac_latch == $past(latch_word))
        else $error("latch missed word");
    chk_latch_hold: assert property (!(latch_valid && latch_ready) |=> $stable(dac_latch))
        else $error("latch moved");
    chk_word_hold: assert property (latch_valid && !latch_ready |=> latch_valid && $stable(latch_word))
        else $error("stalled word lost");
    chk_pending_push: assert property (update_pending |-> ##[0:1] latch_valid)
        else $error("pending not buffered");
    chk_strobe_update: assert property ($fell(load_strobe_n) |-> ##[2:5] update_pending)
        else $error("strobe gave no update");
    chk_chain_quiet: assert property (!chain_enable [*4] |-> !serial_chain_out)
        else $error("chain output active");
    chk_valid_cause: assert property ($rose(latch_valid) |-> $past(update_pending))
        else $error("word without update");
endmodule
bind dac_serial_load_chain dac_load_checker chk (.clock(clock), .rstn(rstn),
    .serial_clk(serial_clk), .serial_data(serial_data), .frame_sync_n(frame_sync_n),
    .load_strobe_n(load_strobe_n), .chain_enable(chain_enable), .latch_ready(latch_ready),
    .latch_valid(latch_valid), .latch_word(latch_word), .dac_latch(dac_latch),
    .dac_updated(dac_updated), .update_pending(update_pending),
    .word_complete(word_complete), .serial_chain_out(serial_chain_out));

// ### host_serial_port.sv
/* Host serial port model: bit clock, data, frame sync and load strobe.
   Assumes a device sampling data on falling bit clock edges; period 64 ns. */
`timescale 1ns/10ps
module host_serial_port (
    output reg serial_clk,
    output reg serial_data,
    output reg frame_sync_n,
    output reg load_strobe_n,
    input wire serial_chain_out
);
    reg [63:0] echo;
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b1;
        frame_sync_n = 1'b1;
        load_strobe_n = 1'b1;
        echo = 64'h0;
    end
    // The clock idles low between frames and during the byte gap.
    task send(input [63:0] w, input integer n, input split);
        integer i;
        begin
            frame_sync_n = 1'b0;
            for (i = n - 1; i >= 0; i = i - 1) begin
                if (split && i == 7) #200;
                serial_clk = 1'b1;
                serial_data = w[i];
                #32;
                echo = {echo[62:0], serial_chain_out};
                serial_clk = 1'b0;
                #32;
            end
            // Data is no longer held after the last bit, while frame sync is still low.
            serial_data = ~serial_data;
            #32;
            frame_sync_n = 1'b1;
        end
    endtask
    // The strobe follows the frame's rising edge after a fixed delay, as a one-shot would.
    task strobe;
        begin
            #40;
            load_strobe_n = 1'b0;
            #104;
            load_strobe_n = 1'b1;
        end
    endtask
endmodule

// ### tb_top.sv
/* Self-checking bench for the serial load chain.
   Assumes the host model drives the serial pins and the bench the rest. */
`timescale 1ns/10ps
module tb_top;
    reg clock = 1'b0;
    reg rstn = 1'b0;
    reg chain_enable = 1'b0;
    reg latch_ready = 1'b1;
    wire serial_clk, serial_data, frame_sync_n, load_strobe_n, serial_chain_out;
    wire latch_valid, dac_updated, update_pending, word_complete;
    wire [15:0] latch_word, dac_latch;
    integer failures = 0;
    integer checks_done = 0;
    integer cycles = 0;
    always #4 clock = ~clock;
    host_serial_port host (.serial_clk(serial_clk), .serial_data(serial_data),
        .frame_sync_n(frame_sync_n), .load_strobe_n(load_strobe_n),
        .serial_chain_out(serial_chain_out));
    dac_serial_load_chain dut (.clock(clock), .rstn(rstn), .serial_clk(serial_clk),
        .serial_data(serial_data), .frame_sync_n(frame_sync_n),
        .load_strobe_n(load_strobe_n), .chain_enable(chain_enable),
        .latch_ready(latch_ready), .latch_valid(latch_valid), .latch_word(latch_word),
        .dac_latch(dac_latch), .dac_updated(dac_updated), .update_pending(update_pending),
        .word_complete(word_complete), .serial_chain_out(serial_chain_out));
    task check(input string name, input [15:0] seen, input [15:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("unexpected %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task test_done;
        begin
            if (failures == 0 && checks_done > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task wait_upd;
        integer n;
        begin
            n = 0;
            while (dac_updated !== 1'b1 && n < 900) begin
                @(negedge clock);
                n = n + 1;
            end
            check("update pulse", {15'h0, dac_updated}, 16'h0001);
        end
    endtask
    task strobed_load;
        begin
            host.send(64'hA5C3, 16, 1'b0);
            repeat (20) @(negedge clock);
            check("held latch", dac_latch, 16'h0000);
            check("word flag", {15'h0, word_complete}, 16'h0001);
            check("chain off", host.echo[15:0], 16'h0000);
            fork host.strobe; wait_upd; join
            check("strobed latch", dac_latch, 16'hA5C3);
        end
    endtask
    task auto_load;
        begin
            host.load_strobe_n = 1'b0;
            repeat (20) @(negedge clock);
            host.send(64'h0FFF, 12, 1'b0);
            repeat (20) @(negedge clock);
            check("short frame", dac_latch, 16'hA5C3);
            fork host.send(64'h3C5A, 16, 1'b1); wait_upd; join
            check("auto latch", dac_latch, 16'h3C5A);
            host.load_strobe_n = 1'b1;
        end
    endtask
    task chain_stall;
        begin
            @(negedge clock);
            chain_enable = 1'b1;
            latch_ready = 1'b0;
            host.send(64'h1234BEEF, 32, 1'b0);
            check("chain out", host.echo[15:0], 16'h1234);
            host.strobe;
            host.send(64'h00FF, 16, 1'b0);
            host.strobe;
            host.send(64'h5555, 16, 1'b0);
            host.strobe;
            repeat (20) @(negedge clock);
            check("stalled latch", dac_latch, 16'h3C5A);
            check("oldest word", latch_word, 16'hBEEF);
            check("stall flags", {14'h0, latch_valid, update_pending}, 16'h0003);
            latch_ready = 1'b1;
            repeat (20) @(negedge clock);
            check("drained latch", dac_latch, 16'h5555);
        end
    endtask
    initial begin
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
        strobed_load;
        auto_load;
        chain_stall;
        test_done;
    end
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 8000) begin
            failures = failures + 1;
            test_done;
        end
    end
endmodule
